// ### src/ebt_pkg.sv
// Constants, register map and state encodings of the 8-bit timer channel
package ebt_pkg;
	// Register byte addresses (16-bit window)
	localparam logic [15:0] ADDR_CONTROL = 16'hffc8;
	localparam logic [15:0] ADDR_STATUS  = 16'hffcc;
	localparam logic [15:0] ADDR_CONST_A = 16'hffd4;
	localparam logic [15:0] ADDR_CONST_B = 16'hffd8;
	localparam logic [15:0] ADDR_COUNTER = 16'hffdc;
	localparam logic [15:0] ADDR_OUT_SEL = 16'hffe0;
	localparam logic [15:0] ADDR_DIV_SEL = 16'hffe4;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [7:0] RST_CONST   = 8'hff;

	// Control register fields
	localparam int BIT_MATCH_B_IRQ_ENABLE = 7;
	localparam int BIT_MATCH_A_IRQ_ENABLE = 6;
	localparam int BIT_WRAP_IRQ_ENABLE    = 5;
	localparam int BIT_CLEAR_SEL_LO       = 3;
	localparam int BIT_SOURCE_SEL_LO      = 0;

	// Status flags share the positions of the enables
	localparam int BIT_FLAG_MATCH_B = 7;
	localparam int BIT_FLAG_MATCH_A = 6;
	localparam int BIT_FLAG_WRAP    = 5;

	// Count source select codes
	localparam logic [2:0] SRC_STOP_0   = 3'h0;
	localparam logic [2:0] SRC_INT_LOW  = 3'h1;
	localparam logic [2:0] SRC_INT_MID  = 3'h2;
	localparam logic [2:0] SRC_INT_HIGH = 3'h3;
	localparam logic [2:0] SRC_STOP_4   = 3'h4;
	localparam logic [2:0] SRC_EXT_RISE = 3'h5;
	localparam logic [2:0] SRC_EXT_FALL = 3'h6;
	localparam logic [2:0] SRC_EXT_BOTH = 3'h7;

	// Counter clear select codes
	localparam logic [1:0] CLR_NONE    = 2'h0;
	localparam logic [1:0] CLR_MATCH_A = 2'h1;
	localparam logic [1:0] CLR_MATCH_B = 2'h2;
	localparam logic [1:0] CLR_EXT_RST = 2'h3;

	// Compare output actions per match
	localparam logic [1:0] OUT_KEEP   = 2'h0;
	localparam logic [1:0] OUT_LOW    = 2'h1;
	localparam logic [1:0] OUT_HIGH   = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;

	// Prescaler taps: divide by 2, 8, 32, 64, 256, 1024
	localparam int PRE_WIDTH = 10;
	localparam int NUM_TAPS  = 6;
	localparam int TAP_BIT [NUM_TAPS] = '{0, 2, 4, 5, 7, 9};
	localparam int TAP_DIV2    = 0;
	localparam int TAP_DIV8    = 1;
	localparam int TAP_DIV32   = 2;
	localparam int TAP_DIV64   = 3;
	localparam int TAP_DIV256  = 4;
	localparam int TAP_DIV1024 = 5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ebt_pkg

// ### src/ebt_prescale.sv
// Free-running system clock prescaler giving one-cycle falling-edge ticks per tap
`timescale 1ns/10ps
module ebt_prescale
	import ebt_pkg::*;
(
	input  wire logic                CLOCK, // System clock
	input  wire logic                SRST,  // Synchronous reset, active high
	output logic      [NUM_TAPS-1:0] TICK   // One pulse per falling edge of each tap
);
	typedef struct packed {
		logic [PRE_WIDTH-1:0] cnt;
		logic [NUM_TAPS-1:0]  tick;
	} ebt_pre_type;

	ebt_pre_type st;
	ebt_pre_type next_st;
	logic [NUM_TAPS-1:0] next_tick;

	// A tap bit falls when all bits up to it are ones and the count advances
	for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
		assign next_tick[i] = &st.cnt[TAP_BIT[i]:0];
	end

	// Next state
	always_comb begin
		next_st      = st;
		next_st.cnt  = st.cnt + 1'b1;
		next_st.tick = next_tick;
	end

	// State register
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign TICK = st.tick;
endmodule : ebt_prescale

// ### src/ebt_timer.sv
// 8-bit timer channel: count source, clear source, compare output, AXI4-Lite registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module ebt_timer
	import ebt_pkg::*;
#(
	parameter int ADDR_W = 16 // AXI address width
)(
	input  wire logic              CLOCK,         // System clock, 10 MHz
	input  wire logic              SRST,          // Synchronous reset, active high
	input  wire logic              EXT_CLK,       // External count clock pin
	input  wire logic              EXT_RST,       // External counter reset pin
	output logic                   TIMER_OUT,     // Compare output level
	output logic                   TIMER_OUT_EN,  // Compare output enable
	output logic                   IRQ,           // Level interrupt
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,  // Write address
	input  wire logic              S_AXI_AWVALID, // Write address valid
	output logic                   S_AXI_AWREADY, // Write address ready
	input  wire logic [31:0]       S_AXI_WDATA,   // Write data
	input  wire logic [3:0]        S_AXI_WSTRB,   // Write strobes
	input  wire logic              S_AXI_WVALID,  // Write data valid
	output logic                   S_AXI_WREADY,  // Write data ready
	output logic [1:0]             S_AXI_BRESP,   // Write response
	output logic                   S_AXI_BVALID,  // Write response valid
	input  wire logic              S_AXI_BREADY,  // Write response ready
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,  // Read address
	input  wire logic              S_AXI_ARVALID, // Read address valid
	output logic                   S_AXI_ARREADY, // Read address ready
	output logic [31:0]            S_AXI_RDATA,   // Read data
	output logic [1:0]             S_AXI_RRESP,   // Read response
	output logic                   S_AXI_RVALID,  // Read data valid
	input  wire logic              S_AXI_RREADY   // Read data ready
);
	// Only the low 16 address bits are decoded, so narrower buses are refused
	if (ADDR_W < 16) begin : g_bad_addr_w
		$error("ADDR_W must be at least 16");
	end

	typedef struct packed {
		logic        aw_ready;
		logic        aw_full;
		logic [15:0] aw_addr;
		logic        w_ready;
		logic        w_full;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        b_valid;
		logic [1:0]  b_resp;
		logic        ar_ready;
		logic        r_valid;
		logic [1:0]  r_resp;
		logic [7:0]  r_data;
		logic [7:0]  ctrl;
		logic [7:0]  status;
		logic [7:0]  const_a;
		logic [7:0]  const_b;
		logic [7:0]  counter;
		logic [3:0]  out_sel;
		logic [1:0]  div_sel;
		logic [2:0]  clk_sync;
		logic [2:0]  rst_sync;
		logic        tmo;
		logic        tmo_en;
		logic        irq;
	} ebt_state_type;

	ebt_state_type st;
	ebt_state_type next_st;

	logic [NUM_TAPS-1:0] tick;
	logic [2:0]          src_sel;
	logic [1:0]          clr_sel;
	logic                clk_rise;
	logic                clk_fall;
	logic                rst_rise;
	logic                int_tick;
	logic                count_tick;
	logic [7:0]          inc;
	logic                hit_a;
	logic                hit_b;
	logic                wrap;
	logic                do_write;
	logic                wr_status;

	ebt_prescale u_prescale (
		.CLOCK (CLOCK),
		.SRST  (SRST),
		.TICK  (tick)
	);

	// Field views and pin edges, taken from the second and third sync stages only
	assign src_sel  = st.ctrl[BIT_SOURCE_SEL_LO +: 3];
	assign clr_sel  = st.ctrl[BIT_CLEAR_SEL_LO +: 2];
	assign clk_rise = st.clk_sync[1] & ~st.clk_sync[2];
	assign clk_fall = ~st.clk_sync[1] & st.clk_sync[2];
	assign rst_rise = st.rst_sync[1] & ~st.rst_sync[2];

	// Internal tap choice; divider select bit 0 refines the source code
	always_comb begin
		case (src_sel)
			SRC_INT_LOW:  int_tick = st.div_sel[0] ? tick[TAP_DIV2] : tick[TAP_DIV8];
			SRC_INT_MID:  int_tick = st.div_sel[0] ? tick[TAP_DIV32] : tick[TAP_DIV64];
			SRC_INT_HIGH: int_tick = st.div_sel[0] ? tick[TAP_DIV256] : tick[TAP_DIV1024];
			default:      int_tick = 1'b0;
		endcase
	end

	// Count enable per source
	always_comb begin
		case (src_sel)
			SRC_EXT_RISE: count_tick = clk_rise;
			SRC_EXT_FALL: count_tick = clk_fall;
			SRC_EXT_BOTH: count_tick = clk_rise | clk_fall;
			default:      count_tick = int_tick;
		endcase
	end

	// Compare on the value the counter is about to take
	assign inc       = st.counter + 8'h01;
	assign hit_a     = count_tick && (inc == st.const_a);
	assign hit_b     = count_tick && (inc == st.const_b);
	assign wrap      = count_tick && (st.counter == 8'hff);
	assign do_write  = st.aw_full && st.w_full && !st.b_valid;
	assign wr_status = do_write && st.w_lane0 && (st.aw_addr == ADDR_STATUS);

	// Next state
	always_comb begin
		next_st = st;
		// Synchronisers: stage 0 is read only by stage 1
		next_st.clk_sync = {st.clk_sync[1:0], EXT_CLK};
		next_st.rst_sync = {st.rst_sync[1:0], EXT_RST};

		// Counter with clear source; external reset edge wins over counting
		if (clr_sel == CLR_EXT_RST && rst_rise) begin
			next_st.counter = 8'h00;
		end else if (count_tick) begin
			if ((clr_sel == CLR_MATCH_A && hit_a) || (clr_sel == CLR_MATCH_B && hit_b)) begin
				next_st.counter = 8'h00;
			end else begin
				next_st.counter = inc;
			end
		end

		// Compare output; when both hit, a B low or high wins over A, but a B toggle is dropped
		if (st.out_sel != 4'h0) begin
			if (hit_a) begin
				case (st.out_sel[1:0])
					OUT_LOW:    next_st.tmo = 1'b0;
					OUT_HIGH:   next_st.tmo = 1'b1;
					OUT_TOGGLE: next_st.tmo = ~st.tmo;
					default:    next_st.tmo = st.tmo;
				endcase
			end
			if (hit_b) begin
				case (st.out_sel[3:2])
					OUT_LOW:    next_st.tmo = 1'b0;
					OUT_HIGH:   next_st.tmo = 1'b1;
					OUT_TOGGLE: next_st.tmo = hit_a ? next_st.tmo : ~st.tmo;
					default:    next_st.tmo = next_st.tmo;
				endcase
			end
		end

		// Write channel: address and data taken in either order
		if (S_AXI_AWVALID && st.aw_ready) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = S_AXI_AWADDR[15:0];
		end
		if (S_AXI_WVALID && st.w_ready) begin
			next_st.w_full  = 1'b1;
			next_st.w_data  = S_AXI_WDATA[7:0];
			next_st.w_lane0 = S_AXI_WSTRB[0];
		end
		if (S_AXI_BREADY && st.b_valid) begin
			next_st.b_valid = 1'b0;
		end
		if (do_write) begin
			next_st.aw_full = 1'b0;
			next_st.w_full  = 1'b0;
			next_st.b_valid = 1'b1;
			next_st.b_resp  = RESP_OKAY;
			case (st.aw_addr)
				ADDR_CONTROL: if (st.w_lane0) next_st.ctrl = st.w_data;
				ADDR_STATUS:  ;
				ADDR_CONST_A: if (st.w_lane0) next_st.const_a = st.w_data;
				ADDR_CONST_B: if (st.w_lane0) next_st.const_b = st.w_data;
				ADDR_COUNTER: ;
				ADDR_OUT_SEL: if (st.w_lane0) next_st.out_sel = st.w_data[3:0];
				ADDR_DIV_SEL: if (st.w_lane0) next_st.div_sel = st.w_data[1:0];
				default:      next_st.b_resp = RESP_SLVERR;
			endcase
		end

		// Sticky flags: zero written clears, one written is ignored, event wins
		next_st.status = 8'h00;
		next_st.status[BIT_FLAG_MATCH_B] = (st.status[BIT_FLAG_MATCH_B] &
			~(wr_status & ~st.w_data[BIT_FLAG_MATCH_B])) | hit_b;
		next_st.status[BIT_FLAG_MATCH_A] = (st.status[BIT_FLAG_MATCH_A] &
			~(wr_status & ~st.w_data[BIT_FLAG_MATCH_A])) | hit_a;
		next_st.status[BIT_FLAG_WRAP] = (st.status[BIT_FLAG_WRAP] &
			~(wr_status & ~st.w_data[BIT_FLAG_WRAP])) | wrap;

		// Read channel answers one cycle after the address is taken
		if (S_AXI_RREADY && st.r_valid) begin
			next_st.r_valid = 1'b0;
		end
		if (S_AXI_ARVALID && st.ar_ready) begin
			next_st.r_valid = 1'b1;
			next_st.r_resp  = RESP_OKAY;
			case (S_AXI_ARADDR[15:0])
				ADDR_CONTROL: next_st.r_data = st.ctrl;
				ADDR_STATUS:  next_st.r_data = st.status;
				ADDR_CONST_A: next_st.r_data = st.const_a;
				ADDR_CONST_B: next_st.r_data = st.const_b;
				ADDR_COUNTER: next_st.r_data = st.counter;
				ADDR_OUT_SEL: next_st.r_data = {4'h0, st.out_sel};
				ADDR_DIV_SEL: next_st.r_data = {6'h00, st.div_sel};
				default: begin
					next_st.r_data = 8'h00;
					next_st.r_resp = RESP_SLVERR;
				end
			endcase
		end

		// Readies derived from next occupancy so outputs stay registered
		next_st.aw_ready = !next_st.aw_full && !next_st.b_valid;
		next_st.w_ready  = !next_st.w_full && !next_st.b_valid;
		next_st.ar_ready = !next_st.r_valid;

		// Output enable and interrupt track the next register contents
		next_st.tmo_en = (next_st.out_sel != 4'h0);
		next_st.irq    = |(next_st.status[BIT_FLAG_WRAP +: 3] &
			next_st.ctrl[BIT_WRAP_IRQ_ENABLE +: 3]);
	end

	// State register
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st          <= '0;
			st.ctrl     <= RST_CONTROL;
			st.status   <= RST_BYTE;
			st.counter  <= RST_BYTE;
			st.const_a  <= RST_CONST;
			st.const_b  <= RST_CONST;
		end else begin
			st <= next_st;
		end
	end

	assign TIMER_OUT     = st.tmo;
	assign TIMER_OUT_EN  = st.tmo_en;
	assign IRQ           = st.irq;
	assign S_AXI_AWREADY = st.aw_ready;
	assign S_AXI_WREADY  = st.w_ready;
	assign S_AXI_BVALID  = st.b_valid;
	assign S_AXI_BRESP   = st.b_resp;
	assign S_AXI_ARREADY = st.ar_ready;
	assign S_AXI_RVALID  = st.r_valid;
	assign S_AXI_RRESP   = st.r_resp;
	assign S_AXI_RDATA   = {24'h000000, st.r_data};

	// Stopped codes hold the counter unless an external reset clear applies
	a_stop_holds: assert property (@(posedge CLOCK) disable iff (SRST)
		((src_sel == SRC_STOP_0 || src_sel == SRC_STOP_4) && clr_sel != CLR_EXT_RST)
		|=> $stable(st.counter)) else $error("counter moved while stopped");

	a_div8_count: assert property (@(posedge CLOCK) disable iff (SRST)
		(src_sel == SRC_INT_LOW && !st.div_sel[0] && tick[TAP_DIV8] && clr_sel == CLR_NONE)
		|=> st.counter == 8'($past(st.counter) + 8'h01)) else $error("divide by 8 tick lost");

	a_pin_rise: assert property (@(posedge CLOCK) disable iff (SRST)
		(src_sel == SRC_EXT_RISE && clr_sel == CLR_NONE && !clk_rise) |=> $stable(st.counter))
		else $error("count without rising pin edge");

	a_pin_fall: assert property (@(posedge CLOCK) disable iff (SRST)
		(src_sel == SRC_EXT_FALL && clr_sel == CLR_NONE && clk_fall)
		|=> st.counter == 8'($past(st.counter) + 8'h01)) else $error("falling pin edge lost");

	a_pin_both: assert property (@(posedge CLOCK) disable iff (SRST)
		(src_sel == SRC_EXT_BOTH && clr_sel == CLR_NONE && (clk_rise || clk_fall))
		|=> st.counter == 8'($past(st.counter) + 8'h01)) else $error("pin edge lost");

	a_match_b_gate: assert property (@(posedge CLOCK) disable iff (SRST)
		(st.status[7:5] == 3'b100) |-> (IRQ == st.ctrl[BIT_MATCH_B_IRQ_ENABLE]))
		else $error("match B request not gated");

	a_flag_write: assert property (@(posedge CLOCK) disable iff (SRST)
		(wr_status && !hit_b) |=> st.status[BIT_FLAG_MATCH_B] ==
		($past(st.status[BIT_FLAG_MATCH_B]) && $past(st.w_data[BIT_FLAG_MATCH_B])))
		else $error("flag write misbehaved");

	a_out_off: assert property (@(posedge CLOCK) disable iff (SRST)
		(st.out_sel == 4'h0) |=> $stable(TIMER_OUT) && (TIMER_OUT_EN == (st.out_sel != 4'h0)))
		else $error("compare output changed while disabled");

	a_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
		(clr_sel == CLR_MATCH_A && hit_a) |=> st.counter == 8'h00)
		else $error("match A did not clear counter");

	a_ext_clear: assert property (@(posedge CLOCK) disable iff (SRST)
		(clr_sel == CLR_EXT_RST && rst_rise) |=> st.counter == 8'h00)
		else $error("external reset did not clear counter");
endmodule : ebt_timer

// ### test/ebt_pins.sv
// Model of the external count clock and counter reset pins
`timescale 1ns/10ps
module ebt_pins (
	input  wire logic CLOCK,   // System clock
	output logic      EXT_CLK, // External count clock pin
	output logic      EXT_RST  // External counter reset pin
);
	// Both pins idle low; the count clock stands still between bursts
	initial begin
		EXT_CLK = 1'b0;
		EXT_RST = 1'b0;
	end

	// Each level held 4 cycles, twice the synchroniser minimum
	task automatic pulse_clk(input int n);
		repeat (n) begin
			@(posedge CLOCK);
			EXT_CLK <= 1'b1;
			repeat (4) @(posedge CLOCK);
			EXT_CLK <= 1'b0;
			repeat (4) @(posedge CLOCK);
		end
	endtask : pulse_clk

	// One reset pulse, long enough for the edge to land before return
	task automatic pulse_rst();
		@(posedge CLOCK);
		EXT_RST <= 1'b1;
		repeat (4) @(posedge CLOCK);
		EXT_RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
	endtask : pulse_rst
endmodule : ebt_pins

// ### test/tb_top.sv
// Self-checking bench of the 8-bit timer channel
`timescale 1ns/10ps
module tb_top;
	import ebt_pkg::*;
	logic        clock, srst, ext_clk, ext_rst, timer_out, timer_out_en, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  c0, dl;
	int          failures, comparisons, cycles;
	int          divs[6] = '{8, 2, 64, 32, 1024, 256};
	logic [15:0] ra[7] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_CONST_A, ADDR_CONST_B,
		ADDR_COUNTER, ADDR_OUT_SEL, ADDR_DIV_SEL};
	logic [7:0]  re[7] = '{RST_CONTROL, RST_BYTE, RST_CONST, RST_CONST,
		RST_BYTE, RST_BYTE, RST_BYTE};

	ebt_timer u_dut (
		.CLOCK(clock), .SRST(srst), .EXT_CLK(ext_clk), .EXT_RST(ext_rst),
		.TIMER_OUT(timer_out), .TIMER_OUT_EN(timer_out_en), .IRQ(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);
	ebt_pins u_pins (.CLOCK(clock), .EXT_CLK(ext_clk), .EXT_RST(ext_rst));

	// 10 MHz system clock
	always #50 clock = ~clock;

	// Hang guard: the full run needs about 24000 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 32000) begin
			failures++;
			$display("unexpected at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
		rs = bresp;
	endtask : wr

	task automatic rd(input logic [15:0] a);
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
		v = rdata;
		rs = rresp;
	endtask : rd

	task automatic expect_reg(input logic [15:0] a, input logic [31:0] e);
		rd(a);
		check(v, e);
	endtask : expect_reg

	// Interrupt is registered, so let two edges pass first
	task automatic expect_irq(input logic e);
		tick(2);
		check({31'h0, irq}, {31'h0, e});
	endtask : expect_irq

	// Counter back to zero through the external reset pin
	task automatic clr_cnt();
		wr(ADDR_CONTROL, 8'h1d);
		u_pins.pulse_rst();
	endtask : clr_cnt

	// Main sequence
	initial begin
		clock = 1'b0;
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 16'h0000;
		araddr = 16'h0000;
		wdata = 32'h0;
		wstrb = 4'hf;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		tick(4);
		srst <= 1'b0;
		tick(1);
		for (int i = 0; i < 7; i++)
			expect_reg(ra[i], {24'h0, re[i]});
		rd(16'hffd0);
		check(v, 32'h0);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(16'hffd0, 8'h55);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		$display("reset values and unmapped place done");
		// Each divider over a window of 16 of its periods; write latency gives slack
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_DIV_SEL, {7'h0, i[0]});
			rd(ADDR_COUNTER);
			c0 = v[7:0];
			wr(ADDR_CONTROL, 8'(1 + i / 2));
			tick(divs[i] * 16);
			wr(ADDR_CONTROL, 8'h00);
			rd(ADDR_COUNTER);
			dl = v[7:0] - c0;
			check({31'h0, dl >= 8'h0e && dl <= 8'h12}, 32'h1);
		end
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CONTROL, {5'h0, k[0] ? SRC_STOP_4 : SRC_STOP_0});
			rd(ADDR_COUNTER);
			c0 = v[7:0];
			tick(300);
			expect_reg(ADDR_COUNTER, {24'h0, c0});
		end
		$display("internal sources done");
		for (int k = 5; k < 8; k++) begin
			wr(ADDR_CONTROL, 8'h18 | 8'(k));
			u_pins.pulse_rst();
			wr(ADDR_CONTROL, 8'(k));
			u_pins.pulse_clk(5);
			expect_reg(ADDR_COUNTER, (k == 7) ? 32'ha : 32'h5);
		end
		$display("external edges done");
		wr(ADDR_CONST_A, 8'h03);
		clr_cnt();
		wr(ADDR_CONTROL, 8'h0d);
		u_pins.pulse_clk(5);
		expect_reg(ADDR_COUNTER, 32'h2);
		expect_reg(ADDR_STATUS, 32'h40);
		expect_irq(1'b0);
		wr(ADDR_CONTROL, 8'h4d);
		expect_irq(1'b1);
		wr(ADDR_STATUS, 8'hff);
		expect_reg(ADDR_STATUS, 32'h40);
		wr(ADDR_STATUS, 8'hbf);
		expect_reg(ADDR_STATUS, 32'h0);
		expect_irq(1'b0);
		$display("match A clear and flags done");
		wr(ADDR_CONST_B, 8'h02);
		clr_cnt();
		wr(ADDR_CONTROL, 8'h15);
		u_pins.pulse_clk(5);
		expect_reg(ADDR_COUNTER, 32'h1);
		expect_reg(ADDR_STATUS, 32'h80);
		expect_irq(1'b0);
		wr(ADDR_CONTROL, 8'h95);
		expect_irq(1'b1);
		wr(ADDR_STATUS, 8'h00);
		expect_irq(1'b0);
		$display("match B gating done");
		// Divide by 2 for 600 cycles passes both constants and wraps
		wr(ADDR_DIV_SEL, 8'h01);
		wr(ADDR_CONTROL, 8'h21);
		tick(600);
		wr(ADDR_CONTROL, 8'h20);
		expect_reg(ADDR_STATUS, 32'he0);
		expect_irq(1'b1);
		wr(ADDR_STATUS, 8'h00);
		expect_irq(1'b0);
		$display("wrap done");
		check({31'h0, timer_out_en}, 32'h0);
		wr(ADDR_OUT_SEL, 8'h02);
		expect_irq(1'b0);
		check({31'h0, timer_out_en}, 32'h1);
		clr_cnt();
		wr(ADDR_CONTROL, 8'h05);
		u_pins.pulse_clk(3);
		check({31'h0, timer_out}, 32'h1);
		// Match B toggle only: the second rise hits constant B and flips the level
		wr(ADDR_OUT_SEL, 8'h0c);
		clr_cnt();
		wr(ADDR_CONTROL, 8'h05);
		u_pins.pulse_clk(2);
		check({31'h0, timer_out}, 32'h0);
		wr(ADDR_OUT_SEL, 8'h00);
		tick(2);
		check({31'h0, timer_out_en}, 32'h0);
		$display("compare output done");
		tally_and_finish();
	end
endmodule : tb_top
